/* inc/gpio_port_regs.svh */
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// register byte offsets
`define OFS_DRIVE      8'h00
`define OFS_DATA       8'h04
`define OFS_INPUT      8'h08
`define OFS_INTMODE    8'h0C
`define OFS_INTSTAT    8'h10
`define OFS_INTMASK    8'h14
`define OFS_INBUF      8'h18
`define OFS_SIO        8'h1C

// reset values
`define RST_DRIVE      24'h000000
`define RST_DATA       8'h00
`define RST_INTMODE    16'h0000
`define RST_INTSTAT    8'h00
`define RST_INTMASK    8'hFF
`define RST_BIT        1'h0
`define RST_BYTE       8'h00
`define RST_NIBBLE     4'h0

// field positions
`define INBUF_LVTTL    0
`define INBUF_DIS_LSB  8
`define SIO_REG_LSB    0
`define SIO_HYST_LSB   8
`define SIO_THR_LSB    16
`define SIO_AG_LSB     24

// bus response codes
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* inc/gpio_port_pkg.sv */
package gpio_port_pkg;

  // per-pin drive mode codes
  typedef enum logic [2:0] {
    DRV_HIZ_ANALOG  = 3'b000,
    DRV_HIZ_DIGITAL = 3'b001,
    DRV_RES_UP      = 3'b010,
    DRV_RES_DOWN    = 3'b011,
    DRV_OD_LOW      = 3'b100,
    DRV_OD_HIGH     = 3'b101,
    DRV_STRONG      = 3'b110,
    DRV_RES_BOTH    = 3'b111
  } drive_mode_type;

  // per-pin interrupt edge selection
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_type;

  // shared pair input threshold selection
  typedef enum logic [1:0] {
    THR_HALF_VDDIO = 2'b00,
    THR_0P4_VDDIO  = 2'b01,
    THR_HALF_VREF  = 2'b10,
    THR_VREF       = 2'b11
  } threshold_type;

endpackage : gpio_port_pkg

/* hw/pin_drive_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_drive_decode
  import gpio_port_pkg::*;
(
  input  wire logic [2:0] mode,
  input  wire logic       data,
  input  wire logic       regulated,
  input  wire logic       ibuf_off,
  output logic            out,
  output logic            oe_n,
  output logic            pull_up,
  output logic            pull_down,
  output logic            ibuf_en
);

  drive_mode_type pin_drive_select;
  logic           pu_raw;
  logic           pd_raw;

  assign pin_drive_select = drive_mode_type'(mode);

  ////////////////////////////////////////////////////////////////////////////
  // drive decode: strong drive, hi-z or resistor per mode and data
  always_comb
  begin
    out    = data;
    oe_n   = 1'b1;
    pu_raw = 1'b0;
    pd_raw = 1'b0;
    unique case (pin_drive_select)
      DRV_HIZ_ANALOG:  oe_n = 1'b1;
      DRV_HIZ_DIGITAL: oe_n = 1'b1;
      DRV_RES_UP:
      begin
        oe_n   = data;
        pu_raw = data;
      end
      DRV_RES_DOWN:
      begin
        oe_n   = ~data;
        pd_raw = ~data;
      end
      DRV_OD_LOW:      oe_n = data;
      DRV_OD_HIGH:     oe_n = ~data;
      DRV_STRONG:      oe_n = 1'b0;
      DRV_RES_BOTH:
      begin
        pu_raw = data;
        pd_raw = ~data;
      end
    endcase
  end

  // resistors are withheld while the regulated output is selected
  assign pull_up   = pu_raw & ~regulated;
  assign pull_down = pd_raw & ~regulated;

  // digital input off in analog hi-z or when disabled, in any mode
  assign ibuf_en = (pin_drive_select != DRV_HIZ_ANALOG) & ~ibuf_off;

endmodule : pin_drive_decode

`default_nettype wire

/* hw/pin_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect
  import gpio_port_pkg::*;
#(
  parameter int PINS = 8
)
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [PINS-1:0]   pin_in,
  input  wire logic [2*PINS-1:0] edge_mode,
  output logic      [PINS-1:0]   event_hit
);

  logic [PINS-1:0] prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // previous input level, kept on the free-running system clock
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prev_q <= '0;
    else
      prev_q <= pin_in;
  end

  // edge match per pin against its own mode; edges only, no levels
  for (genvar i = 0; i < PINS; i++)
  begin : g_pin
    edge_mode_type m;
    logic          rise;
    logic          fall;
    assign m    = edge_mode_type'(edge_mode[2*i+1:2*i]);
    assign rise = pin_in[i] & ~prev_q[i];
    assign fall = ~pin_in[i] & prev_q[i];
    assign event_hit[i] = ((m == EDGE_RISE) & rise) |
                          ((m == EDGE_FALL) & fall) |
                          ((m == EDGE_BOTH) & (rise | fall));
  end

endmodule : pin_edge_detect

`default_nettype wire

/* hw/gpio_port_pin_interrupt.sv */
// Contract
// - the eight pins of the port share one interrupt unit with its own request and a per-pin status register.
// - each pin picks rising, falling, both or no edge as its interrupt event.
// - a matching edge sets that pin's status bit to one and raises the port request.
// - edge detection keeps running in every sleep and low-power mode so a pin edge can wake the chip.
// - only edges are detected; level interrupts are left to programmable logic elsewhere.
// - input thresholds are chosen per port, CMOS by default and low-voltage TTL as option.
// - the digital input buffer of any pin can be turned off whatever its drive mode.
// - each special pin chooses between supply-level high drive and a regulated high level.
// - a special pin on regulated output gets no resistive pull-up or pull-down.
// - special pins come in pairs sharing a reference with half or 0.4 supply, half reference or reference as threshold.
// - the pair reference can take the analog global signal as threshold to act as a comparator.
// - hysteresis can be enabled on the special pin input buffer.
// - at reset every pin is analog hi-z with driver and input buffer both off.
// - in low power each pin holds its configuration and output until software changes it or reset.
// - each pin has a three-bit drive field whose code 000 is the analog hi-z reset state.
//
// Register access over AXI4-Lite and the register addresses were decided locally.

`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_regs.svh"

module gpio_port_pin_interrupt
  import gpio_port_pkg::*;
#(
  parameter int PINS = 8
)
(
  input  wire logic              CLK,
  input  wire logic              NRST,
  // axi4-lite slave
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // pins
  input  wire logic [PINS-1:0]   PIN_I,
  output logic      [PINS-1:0]   PIN_O,
  output logic      [PINS-1:0]   PIN_OE_N,
  output logic      [PINS-1:0]   PIN_PULL_UP,
  output logic      [PINS-1:0]   PIN_PULL_DOWN,
  output logic      [PINS-1:0]   PIN_IBUF_EN,
  output logic                   PORT_LVTTL,
  // special pin analog controls
  output logic      [PINS-1:0]   SIO_REG_EN,
  output logic      [PINS-1:0]   SIO_HYST_EN,
  output logic      [PINS-1:0]   SIO_THRESH_SEL,
  output logic      [PINS/2-1:0] SIO_AG_SEL,
  // port interrupt request
  output logic                   IRQ
);

  localparam int PAIRS = PINS / 2;

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [3*PINS-1:0] port_drive_select_reg_q;
  logic [PINS-1:0]   data_q;
  logic [2*PINS-1:0] intmode_q;
  logic [PINS-1:0]   stat_q;
  logic [PINS-1:0]   stat_d;
  logic [PINS-1:0]   mask_q;
  logic              lvttl_q;
  logic [PINS-1:0]   ibuf_dis_q;
  logic [PINS-1:0]   reg_en_q;
  logic [PINS-1:0]   hyst_q;
  logic [PINS-1:0]   thr_q;
  logic [PAIRS-1:0]  ag_q;

  // bus handshake state
  logic              aw_held_q;
  logic              w_held_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_write;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic        wr_drive;
  logic        wr_data;
  logic        wr_intmode;
  logic        wr_intstat;
  logic        wr_intmask;
  logic        wr_inbuf;
  logic        wr_sio;
  logic        wr_hit;
  logic        rd_stat;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic [PINS-1:0] in_gated;
  logic [PINS-1:0] evt;

  // handshake ready terms
  assign S_AXI_AWREADY = ~aw_held_q & ~bvalid_q;
  assign S_AXI_WREADY  = ~w_held_q & ~bvalid_q;
  assign S_AXI_ARREADY = ~rvalid_q;
  assign aw_hs    = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs     = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_hs    = S_AXI_ARVALID & S_AXI_ARREADY;
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;

  // byte-lane mask and merged write value helpers
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wval  = wdata_q & wmask;

  // write target decode
  assign wr_drive   = do_write & (awaddr_q == `OFS_DRIVE);
  assign wr_data    = do_write & (awaddr_q == `OFS_DATA);
  assign wr_intmode = do_write & (awaddr_q == `OFS_INTMODE);
  assign wr_intstat = do_write & (awaddr_q == `OFS_INTSTAT);
  assign wr_intmask = do_write & (awaddr_q == `OFS_INTMASK);
  assign wr_inbuf   = do_write & (awaddr_q == `OFS_INBUF);
  assign wr_sio     = do_write & (awaddr_q == `OFS_SIO);
  assign wr_hit     = wr_drive | wr_data | wr_intmode | wr_intstat |
                      wr_intmask | wr_inbuf | wr_sio | (awaddr_q == `OFS_INPUT);

  // read selection; status read is one clearing event, a status write of ones the other
  assign rd_stat = ar_hs & (S_AXI_ARADDR == `OFS_INTSTAT);
  assign rd_hit  = (S_AXI_ARADDR == `OFS_DRIVE)   | (S_AXI_ARADDR == `OFS_DATA)    |
                   (S_AXI_ARADDR == `OFS_INPUT)   | (S_AXI_ARADDR == `OFS_INTMODE) |
                   (S_AXI_ARADDR == `OFS_INTSTAT) | (S_AXI_ARADDR == `OFS_INTMASK) |
                   (S_AXI_ARADDR == `OFS_INBUF)   | (S_AXI_ARADDR == `OFS_SIO);
  assign rd_word =
    ({32{S_AXI_ARADDR == `OFS_DRIVE}}   & 32'(port_drive_select_reg_q)) |
    ({32{S_AXI_ARADDR == `OFS_DATA}}    & 32'(data_q))                  |
    ({32{S_AXI_ARADDR == `OFS_INPUT}}   & 32'(in_gated))                |
    ({32{S_AXI_ARADDR == `OFS_INTMODE}} & 32'(intmode_q))               |
    ({32{S_AXI_ARADDR == `OFS_INTSTAT}} & 32'(stat_q))                  |
    ({32{S_AXI_ARADDR == `OFS_INTMASK}} & 32'(mask_q))                  |
    ({32{S_AXI_ARADDR == `OFS_INBUF}}   & (32'(lvttl_q) |
                                           (32'(ibuf_dis_q) << `INBUF_DIS_LSB))) |
    ({32{S_AXI_ARADDR == `OFS_SIO}}     & (32'(reg_en_q) |
                                           (32'(hyst_q) << `SIO_HYST_LSB) |
                                           (32'(thr_q) << `SIO_THR_LSB) |
                                           (32'(ag_q) << `SIO_AG_LSB)));

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      if (w_hs)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_q & S_AXI_BREADY)
        bvalid_q <= 1'b0;
    end
  end

  // read channel: one-cycle answer, held until rready
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_q & S_AXI_RREADY)
      rvalid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; reset gives analog hi-z everywhere
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      port_drive_select_reg_q <= `RST_DRIVE;
      data_q     <= `RST_DATA;
      intmode_q  <= `RST_INTMODE;
      mask_q     <= `RST_INTMASK;
      lvttl_q    <= `RST_BIT;
      ibuf_dis_q <= `RST_BYTE;
      reg_en_q   <= `RST_BYTE;
      hyst_q     <= `RST_BYTE;
      thr_q      <= `RST_BYTE;
      ag_q       <= `RST_NIBBLE;
    end
    else
    begin
      // values change only on a software write, so they hold in low power
      if (wr_drive)
        port_drive_select_reg_q <= (port_drive_select_reg_q & ~wmask[3*PINS-1:0]) |
                                   wval[3*PINS-1:0];
      if (wr_data)
        data_q <= (data_q & ~wmask[PINS-1:0]) | wval[PINS-1:0];
      if (wr_intmode)
        intmode_q <= (intmode_q & ~wmask[2*PINS-1:0]) | wval[2*PINS-1:0];
      if (wr_intmask & wstrb_q[0])
        mask_q <= wdata_q[PINS-1:0];
      if (wr_inbuf & wstrb_q[0])
        lvttl_q <= wdata_q[`INBUF_LVTTL];
      if (wr_inbuf & wstrb_q[1])
        ibuf_dis_q <= wdata_q[`INBUF_DIS_LSB +: PINS];
      if (wr_sio & wstrb_q[0])
        reg_en_q <= wdata_q[`SIO_REG_LSB +: PINS];
      if (wr_sio & wstrb_q[1])
        hyst_q <= wdata_q[`SIO_HYST_LSB +: PINS];
      if (wr_sio & wstrb_q[2])
        thr_q <= wdata_q[`SIO_THR_LSB +: PINS];
      if (wr_sio & wstrb_q[3])
        ag_q <= wdata_q[`SIO_AG_LSB +: PAIRS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive decode, one instance per pin
  for (genvar i = 0; i < PINS; i++)
  begin : g_drv
    pin_drive_decode u_drv (
      .mode      (port_drive_select_reg_q[3*i+2:3*i]),
      .data      (data_q[i]),
      .regulated (reg_en_q[i]),
      .ibuf_off  (ibuf_dis_q[i]),
      .out       (PIN_O[i]),
      .oe_n      (PIN_OE_N[i]),
      .pull_up   (PIN_PULL_UP[i]),
      .pull_down (PIN_PULL_DOWN[i]),
      .ibuf_en   (PIN_IBUF_EN[i])
    );
  end

  // disabled buffers read as low; switching one off on a high pin gives a falling edge
  assign in_gated = PIN_I & PIN_IBUF_EN;

  ////////////////////////////////////////////////////////////////////////////
  // port interrupt unit: edge detect on all pins
  pin_edge_detect #(
    .PINS (PINS)
  ) u_edge (
    .clk       (CLK),
    .nrst      (NRST),
    .pin_in    (in_gated),
    .edge_mode (intmode_q),
    .event_hit (evt)
  );

  // sticky status: an event in the clearing cycle wins
  assign stat_d = (stat_q & ~({PINS{rd_stat}} |
                  (wval[PINS-1:0] & {PINS{wr_intstat}}))) | evt;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      stat_q <= `RST_INTSTAT;
    else
      stat_q <= stat_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign IRQ            = |(stat_q & mask_q);
  assign PORT_LVTTL     = lvttl_q;
  assign SIO_REG_EN     = reg_en_q;
  assign SIO_HYST_EN    = hyst_q;
  assign SIO_THRESH_SEL = thr_q;
  assign SIO_AG_SEL     = ag_q;
  assign S_AXI_BVALID   = bvalid_q;
  assign S_AXI_BRESP    = bresp_q;
  assign S_AXI_RVALID   = rvalid_q;
  assign S_AXI_RDATA    = rdata_q;
  assign S_AXI_RRESP    = rresp_q;

endmodule : gpio_port_pin_interrupt

`default_nettype wire

/* testbench/gpio_port_pin_interrupt_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module gpio_port_pin_interrupt_chk
  import gpio_port_pkg::*;
#(
  parameter int PINS = 8
)
(
  input wire logic            CLK,
  input wire logic            NRST,
  input wire logic            S_AXI_AWVALID,
  input wire logic            S_AXI_AWREADY,
  input wire logic            S_AXI_WVALID,
  input wire logic            S_AXI_WREADY,
  input wire logic            S_AXI_BVALID,
  input wire logic            S_AXI_ARVALID,
  input wire logic            S_AXI_ARREADY,
  input wire logic [31:0]     S_AXI_RDATA,
  input wire logic            S_AXI_RVALID,
  input wire logic            S_AXI_RREADY,
  input wire logic [PINS-1:0] PIN_OE_N,
  input wire logic [PINS-1:0] PIN_PULL_UP,
  input wire logic [PINS-1:0] PIN_PULL_DOWN,
  input wire logic [PINS-1:0] PIN_IBUF_EN,
  input wire logic            PORT_LVTTL,
  input wire logic [PINS-1:0] SIO_REG_EN,
  input wire logic            IRQ
);
  // one clock domain for every check
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_rst;
    $rose(NRST) |-> PIN_OE_N == '1 && PIN_IBUF_EN == '0 && !PORT_LVTTL && SIO_REG_EN == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not in analog hi-z after reset");
  property p_regpull;
    (SIO_REG_EN & (PIN_PULL_UP | PIN_PULL_DOWN)) == '0;
  endproperty
  a_regpull: assert property (p_regpull) else $error("pull on regulated pin");
  property p_pulloe;
    ((PIN_PULL_UP | PIN_PULL_DOWN) & ~PIN_OE_N) == '0;
  endproperty
  a_pulloe: assert property (p_pulloe) else $error("pull while driving strongly");
  property p_pullx;
    (PIN_PULL_UP & PIN_PULL_DOWN) == '0;
  endproperty
  a_pullx: assert property (p_pullx) else $error("pull up and down together");
  property p_hold;
    ($changed(PIN_OE_N) || $changed(PIN_IBUF_EN) || $changed(SIO_REG_EN)) |-> $rose(S_AXI_BVALID);
  endproperty
  a_hold: assert property (p_hold) else $error("pin setup changed without a write");
  property p_irqkeep;
    IRQ && !S_AXI_ARVALID && !S_AXI_AWVALID && !$past(S_AXI_AWVALID) |=> IRQ;
  endproperty
  a_irqkeep: assert property (p_irqkeep) else $error("request dropped without clear");
  property p_rd;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rhold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer not held");
  property p_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
endmodule : gpio_port_pin_interrupt_chk

bind gpio_port_pin_interrupt gpio_port_pin_interrupt_chk #(.PINS(PINS)) chk (
  .CLK(CLK), .NRST(NRST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PIN_OE_N(PIN_OE_N),
  .PIN_PULL_UP(PIN_PULL_UP), .PIN_PULL_DOWN(PIN_PULL_DOWN), .PIN_IBUF_EN(PIN_IBUF_EN),
  .PORT_LVTTL(PORT_LVTTL), .SIO_REG_EN(SIO_REG_EN), .IRQ(IRQ));

`default_nettype wire

/* testbench/pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_partner #(
  parameter int PINS = 8
)
(
  input  wire logic            clk,
  input  wire logic [PINS-1:0] pin_o,
  input  wire logic [PINS-1:0] oe_n,
  input  wire logic [PINS-1:0] pull_up,
  input  wire logic [PINS-1:0] pull_down,
  input  wire logic [PINS-1:0] ext_lvl,
  input  wire logic [PINS-1:0] ext_en,
  output logic      [PINS-1:0] pin_i
);
  logic [PINS-1:0] last_q;

  // remember the wire so an undriven line drifts away from it
  always_ff @(posedge clk)
    last_q <= pin_i;

  // device drive wins, then the outside driver, then a resistor, else drifting
  assign pin_i = (~oe_n & pin_o) | (oe_n & ext_en & ext_lvl)
               | (oe_n & ~ext_en & (pull_up | (~pull_down & ~last_q)));
endmodule : pin_partner

`default_nettype wire

/* testbench/gpio_port_pin_interrupt_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_regs.svh"

module gpio_port_pin_interrupt_test
  import gpio_port_pkg::*;
;
  logic        clk = 1'b0, nrst = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ext_lvl = 8'h00, ext_en = 8'hFF;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0, sag, strb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, lvttl;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, dv;
  logic [7:0]  pin_i, pin_o, oe_n, pu, pd, ibuf, sreg, shyst, sthr;
  int          failures = 0, tests_run = 0;

  // drive table {oe_n, up, down, ibuf} indexed by {code, data}
  localparam logic [3:0] TBL [16] = '{4'h8, 4'h8, 4'h9, 4'h9, 4'h1, 4'hD, 4'hB, 4'h1,
                                      4'h1, 4'h9, 4'h9, 4'h1, 4'h1, 4'h1, 4'hB, 4'hD};

  always #5 clk = ~clk;

  gpio_port_pin_interrupt #(.PINS(8)) dut (
    .CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N(oe_n), .PIN_PULL_UP(pu), .PIN_PULL_DOWN(pd),
    .PIN_IBUF_EN(ibuf), .PORT_LVTTL(lvttl), .SIO_REG_EN(sreg), .SIO_HYST_EN(shyst),
    .SIO_THRESH_SEL(sthr), .SIO_AG_SEL(sag), .IRQ(irq));

  pin_partner #(.PINS(8)) far (
    .clk(clk), .pin_o(pin_o), .oe_n(oe_n), .pull_up(pu),
    .pull_down(pd), .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_i(pin_i));

  ////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel is released right after the edge that takes it
    while (!(ta && tw))
    begin
      @(posedge clk);
      ta = ta | (awready === 1'b1);
      tw = tw | (wready === 1'b1);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    // response taken at the edge where bvalid is seen high
    while (bvalid !== 1'b1)
      @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // address stands until the edge that takes it
    do
      @(posedge clk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    // data taken at the edge where rvalid is seen high
    while (rvalid !== 1'b1)
      @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic wchk(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk(rs, `RESP_OKAY);
  endtask : wchk

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, dv, rs);
    chk({dv, rs}, {e, `RESP_OKAY});
  endtask : rchk

  task automatic pins(input logic [7:0] v, input int wait_n);
    @(posedge clk);
    ext_lvl <= v;
    repeat (wait_n) @(posedge clk);
  endtask : pins

  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    chk({oe_n, ibuf, pu | pd, pin_o}, {8'hFF, 8'h00, 8'h00, 8'h00});
    chk({lvttl, irq, sreg, shyst, sthr, sag}, 30'h0);
    rchk(`OFS_DRIVE, 32'h0);
    rchk(`OFS_INTMASK, 32'hFF);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_edges;
    wchk(`OFS_DRIVE, 32'h0024_9249);
    wchk(`OFS_INTMODE, 32'h0000_E4E4);
    pins(8'hFF, 4);
    chk(irq, 1'b1);
    rchk(`OFS_INTSTAT, 32'hAA);
    chk(irq, 1'b0);
    pins(8'hFF, 20);
    rchk(`OFS_INTSTAT, 32'h00);
    pins(8'h00, 4);
    rchk(`OFS_INTSTAT, 32'hCC);
    wchk(`OFS_INTMASK, 32'h0);
    pins(8'hFF, 4);
    chk(irq, 1'b0);
    rchk(`OFS_INTSTAT, 32'hAA);
    wchk(`OFS_INTMASK, 32'hFF);
    pins(8'h00, 4);
    wchk(`OFS_INTSTAT, 32'h0C);
    chk(irq, 1'b1);
    rchk(`OFS_INTSTAT, 32'hC0);
    $display("t_edges done");
  endtask : t_edges

  task automatic t_drive;
    logic [3:0] e;
    ext_en <= 8'h00;
    for (int c = 0; c < 16; c++)
    begin
      wchk(`OFS_DATA, {24'h0, {8{c[0]}}});
      wchk(`OFS_DRIVE, {8'h00, {8{c[3:1]}}});
      e = TBL[c];
      chk({pin_o, oe_n, pu, pd, ibuf}, {{8{c[0]}}, {8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}});
    end
    wchk(`OFS_SIO, 32'hFF);
    chk({oe_n, pu, pd}, {8'hFF, 16'h0});
    wchk(`OFS_DATA, 32'h0);
    chk({oe_n, pu, pd}, {8'hFF, 16'h0});
    wchk(`OFS_SIO, 32'h0);
    ext_en <= 8'hFF;
    $display("t_drive done");
  endtask : t_drive

  task automatic t_sio;
    wchk(`OFS_SIO, 32'h0AE4_A53C);
    chk({sag, sthr, shyst, sreg}, 28'hAE4A53C);
    rchk(`OFS_SIO, 32'h0AE4_A53C);
    strb = 4'h2;
    wchk(`OFS_SIO, 32'hFFFF_FFFF);
    strb = 4'hF;
    rchk(`OFS_SIO, 32'h0AE4_FF3C);
    wchk(`OFS_DRIVE, 32'h0024_9249);
    pins(8'h5A, 2);
    rchk(`OFS_INPUT, 32'h5A);
    wchk(`OFS_INBUF, 32'h0000_FF01);
    chk({ibuf, lvttl}, 9'h001);
    rchk(`OFS_INPUT, 32'h0);
    wchk(`OFS_INBUF, 32'h0);
    chk(lvttl, 1'b0);
    $display("t_sio done");
  endtask : t_sio

  task automatic t_bad_addr;
    wr(8'h20, 32'hFFFF_FFFF, rs);
    chk(rs, `RESP_SLVERR);
    rd(8'h20, dv, rs);
    chk({dv, rs}, {32'h0, `RESP_SLVERR});
    $display("t_bad_addr done");
  endtask : t_bad_addr

  task automatic t_retain;
    wchk(`OFS_DATA, 32'hA5);
    wchk(`OFS_DRIVE, 32'h00DB_6DB6);
    pins(8'h00, 50);
    chk({pin_o, oe_n}, {8'hA5, 8'h00});
    do_reset;
    $display("t_retain done");
    t_reset;
  endtask : t_retain

  ////////////////////////////////////////////////////////////
  // verdict and run control
  task automatic report_and_stop;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial
  begin
    do_reset;
    t_reset;
    t_edges;
    t_drive;
    t_sio;
    t_bad_addr;
    t_retain;
    report_and_stop;
  end

  // watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule : gpio_port_pin_interrupt_test

`default_nettype wire
